// ### core/port_media_pkg.sv
// shared constants, types and helpers for the port media and clock phase block
package port_media_pkg;

   // bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // printed register indices; the byte address is four times the index
   localparam logic [7:0] IDX_RSVD_CTRL_A = 8'hCF;
   localparam logic [7:0] IDX_TEST_B = 8'hDF;
   localparam logic [7:0] IDX_MEDIA = 8'hEF;
   localparam logic [7:0] IDX_TEST_C = 8'hFF;
   localparam logic [ADDR_W-1:0] ADDR_RSVD_CTRL_A = {2'b00, IDX_RSVD_CTRL_A, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_TEST_B = {2'b00, IDX_TEST_B, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MEDIA = {2'b00, IDX_MEDIA, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_TEST_C = {2'b00, IDX_TEST_C, 2'b00};

   // shaper control registers
   localparam logic [ADDR_W-1:0] ADDR_QUEUE_MODE = 12'h400;
   localparam logic [ADDR_W-1:0] ADDR_SHAPER_STATUS = 12'h404;
   localparam logic [ADDR_W-1:0] ADDR_RATE_Q0 = 12'h410;
   localparam logic [ADDR_W-1:0] ADDR_RATE_Q1 = 12'h414;
   localparam logic [ADDR_W-1:0] ADDR_RATE_Q2 = 12'h418;
   localparam logic [ADDR_W-1:0] ADDR_RATE_Q3 = 12'h41C;
   localparam logic [ADDR_W-1:0] ADDR_RATIO_Q0 = 12'h420;
   localparam logic [ADDR_W-1:0] ADDR_RATIO_Q1 = 12'h424;
   localparam logic [ADDR_W-1:0] ADDR_RATIO_Q2 = 12'h428;

   // reset values and field positions
   localparam logic [7:0] RST_RSVD_CTRL_A = 8'h15;
   localparam logic [7:0] RST_TEST_B = 8'h0C;
   localparam logic [6:0] RST_MEDIA_LOW = 7'h32;
   localparam logic [6:0] RST_RATE = 7'h00;
   localparam logic [6:0] RST_RATIO = 7'h40;
   localparam int MEDIA_FIBER_BIT = 7;
   localparam int CLK_INV_BIT = 4;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // rate code map
   localparam logic [6:0] RATE_NO_LIMIT_A = 7'h00;
   localparam logic [6:0] RATE_NO_LIMIT_B = 7'h64;
   localparam logic [6:0] RATE_MBPS_MAX = 7'h63;
   localparam logic [6:0] RATE_KBPS_MIN = 7'h65;
   localparam logic [6:0] RATE_KBPS_MAX = 7'h73;
   localparam logic [16:0] KBPS_STEP = 17'h00040;
   localparam logic [16:0] KBPS_PER_MBPS = 17'h003E8;

   // byte credit pacing: one byte per threshold / kbps cycles
   localparam int CLK_MHZ = 100;
   localparam int BITS_PER_BYTE = 8;
   localparam logic [20:0] BYTE_THRESH = 21'(CLK_MHZ * 1000 * BITS_PER_BYTE);

   // a lower queue spends this much ratio credit per byte
   localparam int RATIO_UNIT = 64;

   typedef enum logic [1:0] {QM_ONE, QM_TWO, QM_FOUR} qmode_t;

   // rate code to kbps; zero means unlimited
   function automatic logic [16:0] rate_kbps(input logic [6:0] code);
      logic [16:0] k;
      k = 17'h00000;
      if (code != RATE_NO_LIMIT_A && code <= RATE_MBPS_MAX) begin
         k = 17'(17'(code) * KBPS_PER_MBPS);
      end else if (code >= RATE_KBPS_MIN && code <= RATE_KBPS_MAX) begin
         k = 17'(17'(code - RATE_NO_LIMIT_B) * KBPS_STEP);
      end
      return k;
   endfunction

endpackage

// ### core/rate_shaper.sv
// byte credit pacer for one rate code
`timescale 1ns/10ps
module rate_shaper (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [6:0] rateCode,
   output logic creditPulse,
   output logic unlimited
);
   import port_media_pkg::*;

   typedef struct packed {
      logic [19:0] acc;
      logic pulse;
      logic unlim;
   } shaper_t;

   shaper_t s_r;
   shaper_t s_nxt;

   // fractional accumulator: exact long-run average for any code
   always_comb begin
      logic [16:0] kbps;
      logic [20:0] sum;
      kbps = rate_kbps(rateCode);
      sum = {1'b0, s_r.acc} + 21'(kbps);
      s_nxt = s_r;
      s_nxt.pulse = 1'b0;
      s_nxt.unlim = (kbps == 17'h00000);
      if (s_nxt.unlim) begin
         s_nxt.acc = 20'h00000;
         s_nxt.pulse = 1'b1;
      end else if (sum >= BYTE_THRESH) begin
         s_nxt.acc = 20'(sum - BYTE_THRESH);
         s_nxt.pulse = 1'b1;
      end else begin
         s_nxt.acc = sum[19:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign creditPulse = s_r.pulse;
   assign unlimited = s_r.unlim;
endmodule

// ### core/port_media_and_clock_phase_ctrl.sv
// register bank for port 3 media, rx clock phase and egress queue shaping
//
// Summary of operation
// - media bit 0 copper, 1 fiber port 3
// - bit 4 inverts rmii receive reference clock
// - without inversion option bit 4 reads zero
// - top queue paced exactly by its code
// - lower queues paced by weighted ratio
// - codes: 1-99 Mbps, 0/100 free, kbps steps
`timescale 1ns/10ps
module port_media_and_clock_phase_ctrl #(
   parameter bit HAS_CLK_INVERT = 1'b1,
   parameter int CREDIT_W = 9
) (
   input wire logic clk,
   input wire logic resetn,
   // axi4-lite slave
   input wire logic awvalid,
   output logic awready,
   input wire logic [port_media_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [port_media_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [port_media_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [port_media_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // port 3 media and switch-side rmii clock
   output logic port3Fiber,
   input wire logic switchSideReducedMiiMode,
   output logic switchRxRefClockOut,
   // egress queues, one byte per grant
   input wire logic [3:0] queueByteReady,
   output logic [3:0] queueByteSend
);
   import port_media_pkg::*;

   localparam logic [CREDIT_W-1:0] CREDIT_MAX = '1;
   localparam logic [CREDIT_W-1:0] TOP_COST = CREDIT_W'(1);
   localparam logic [CREDIT_W-1:0] LOW_COST = CREDIT_W'(RATIO_UNIT);

   // refuse credit widths outside 8 to 16 bits
   if (CREDIT_W < 8 || CREDIT_W > 16) begin : g_check
      $error("CREDIT_W must be between 8 and 16");
   end

   typedef struct packed {
      // write channel capture
      logic awPend;
      logic [ADDR_W-1:0] awAddr;
      logic wPend;
      logic [7:0] wData;
      logic wLane0;
      logic awRdy;
      logic wRdy;
      logic bValid;
      logic [1:0] bResp;
      // read channel
      logic arRdy;
      logic rValid;
      logic [7:0] rData;
      logic [1:0] rResp;
      // control fields
      logic fiber;
      logic clkInv;
      qmode_t qmode;
      logic [3:0][6:0] rate;
      logic [2:0][6:0] ratio;
      // shaping and clock
      logic [3:0][CREDIT_W-1:0] credit;
      logic [3:0] send;
      logic refDiv;
      logic refOut;
   } ctrl_t;

   ctrl_t s_r;
   ctrl_t s_nxt;
   logic topPulse;
   logic topFree;
   logic [6:0] topCode;

   // top queue index for the programmed queue count
   function automatic logic [1:0] top_queue(input qmode_t m);
      logic [1:0] t;
      t = 2'd0;
      unique case (m)
         QM_ONE: t = 2'd0;
         QM_TWO: t = 2'd1;
         QM_FOUR: t = 2'd3;
      endcase
      return t;
   endfunction

   // add with saturation at the credit ceiling
   function automatic logic [CREDIT_W-1:0] sat_add(input logic [CREDIT_W-1:0] a,
                                                   input logic [CREDIT_W-1:0] b);
      logic [CREDIT_W:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      return sum[CREDIT_W] ? CREDIT_MAX : sum[CREDIT_W-1:0];
   endfunction

   assign topCode = s_r.rate[top_queue(s_r.qmode)];

   // top queue pacing at the exact coded rate
   rate_shaper u_top_shaper (
      .clk(clk),
      .resetn(resetn),
      .rateCode(topCode),
      .creditPulse(topPulse),
      .unlimited(topFree)
   );

   always_comb begin
      logic [1:0] top;
      logic granted;
      logic doWrite;
      logic [ADDR_W-1:0] wa;
      logic [CREDIT_W-1:0] cost;
      top = top_queue(s_r.qmode);
      granted = 1'b0;
      doWrite = 1'b0;
      wa = '0;
      cost = '0;
      s_nxt = s_r;

      // response handshakes complete first so a slot frees at once
      if (s_r.bValid && bready) begin
         s_nxt.bValid = 1'b0;
      end
      if (s_r.rValid && rready) begin
         s_nxt.rValid = 1'b0;
      end

      // address and data may arrive in either order
      if (awvalid && s_r.awRdy) begin
         s_nxt.awPend = 1'b1;
         s_nxt.awAddr = awaddr;
      end
      if (wvalid && s_r.wRdy) begin
         s_nxt.wPend = 1'b1;
         s_nxt.wData = wdata[7:0];
         s_nxt.wLane0 = wstrb[0];
      end

      // commit once both halves are held and no response waits
      if (s_nxt.awPend && s_nxt.wPend && !s_r.bValid) begin
         doWrite = 1'b1;
         wa = s_nxt.awAddr;
         s_nxt.awPend = 1'b0;
         s_nxt.wPend = 1'b0;
         s_nxt.bValid = 1'b1;
         s_nxt.bResp = RESP_OKAY;
      end

      // register writes; read-only fields keep their value
      if (doWrite) begin
         unique case (wa)
            ADDR_RSVD_CTRL_A, ADDR_TEST_B, ADDR_SHAPER_STATUS: begin
               // read-only content, write accepted and dropped
            end
            ADDR_MEDIA: begin
               if (s_nxt.wLane0) begin
                  s_nxt.fiber = s_nxt.wData[MEDIA_FIBER_BIT];
               end
            end
            ADDR_TEST_C: begin
               if (s_nxt.wLane0 && HAS_CLK_INVERT) begin
                  s_nxt.clkInv = s_nxt.wData[CLK_INV_BIT];
               end
            end
            ADDR_QUEUE_MODE: begin
               // code 3 is not a queue count, so it is ignored
               if (s_nxt.wLane0 && s_nxt.wData[1:0] != 2'b11) begin
                  s_nxt.qmode = qmode_t'(s_nxt.wData[1:0]);
               end
            end
            ADDR_RATE_Q0, ADDR_RATE_Q1, ADDR_RATE_Q2, ADDR_RATE_Q3: begin
               if (s_nxt.wLane0) begin
                  s_nxt.rate[wa[3:2]] = s_nxt.wData[6:0];
               end
            end
            ADDR_RATIO_Q0, ADDR_RATIO_Q1, ADDR_RATIO_Q2: begin
               if (s_nxt.wLane0) begin
                  s_nxt.ratio[wa[3:2]] = s_nxt.wData[6:0];
               end
            end
            default: begin
               s_nxt.bResp = RESP_SLVERR;
            end
         endcase
      end

      // read decode, answered one edge after the address is taken
      if (arvalid && s_r.arRdy) begin
         s_nxt.rValid = 1'b1;
         s_nxt.rResp = RESP_OKAY;
         s_nxt.rData = 8'h00;
         unique case (araddr)
            ADDR_RSVD_CTRL_A: s_nxt.rData = RST_RSVD_CTRL_A;
            ADDR_TEST_B: s_nxt.rData = RST_TEST_B;
            ADDR_MEDIA: s_nxt.rData = {s_r.fiber, RST_MEDIA_LOW};
            // low nibble and top bits reserved, read as zero
            ADDR_TEST_C: s_nxt.rData = 8'(s_r.clkInv) << CLK_INV_BIT;
            ADDR_QUEUE_MODE: s_nxt.rData = {6'h00, s_r.qmode};
            ADDR_SHAPER_STATUS: s_nxt.rData = {3'h0, topFree, s_r.send};
            ADDR_RATE_Q0, ADDR_RATE_Q1, ADDR_RATE_Q2, ADDR_RATE_Q3: begin
               s_nxt.rData = {1'b0, s_r.rate[araddr[3:2]]};
            end
            ADDR_RATIO_Q0, ADDR_RATIO_Q1, ADDR_RATIO_Q2: begin
               s_nxt.rData = {1'b0, s_r.ratio[araddr[3:2]]};
            end
            default: s_nxt.rResp = RESP_SLVERR;
         endcase
      end

      // one transfer of each kind at a time
      s_nxt.awRdy = !s_nxt.awPend && !s_nxt.bValid;
      s_nxt.wRdy = !s_nxt.wPend && !s_nxt.bValid;
      s_nxt.arRdy = !s_nxt.rValid;

      // credit: top earns one byte per pulse, queues above top hold none
      for (int q = 0; q < 4; q++) begin
         if (topPulse && !topFree && 2'(q) == top) begin
            s_nxt.credit[q] = sat_add(s_r.credit[q], TOP_COST);
         end
         if (2'(q) > top) begin
            s_nxt.credit[q] = '0;
         end
      end
      // lower queues earn their ratio; queue 3 is never below the top
      for (int q = 0; q < 3; q++) begin
         if (topPulse && !topFree && 2'(q) < top) begin
            s_nxt.credit[q] = sat_add(s_r.credit[q], CREDIT_W'(s_r.ratio[q]));
         end
      end

      // strict priority among queues that hold enough credit
      s_nxt.send = 4'h0;
      for (int q = 3; q >= 0; q--) begin
         cost = (2'(q) == top) ? TOP_COST : LOW_COST;
         if (!granted && 2'(q) <= top && queueByteReady[q]) begin
            if (topFree) begin
               // unlimited code lets every active queue run freely
               granted = 1'b1;
               s_nxt.send[q] = 1'b1;
            end else if (s_nxt.credit[q] >= cost) begin
               granted = 1'b1;
               s_nxt.send[q] = 1'b1;
               s_nxt.credit[q] = s_nxt.credit[q] - cost;
            end
         end
      end

      // half-rate reference clock, driven only in rmii mode and held low otherwise
      s_nxt.refDiv = !s_r.refDiv;
      s_nxt.refOut = switchSideReducedMiiMode &&
                     (s_nxt.refDiv ^ s_r.clkInv);
   end

   // single state register for the block; the top queue shaper keeps its own
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.awRdy <= 1'b1;
         s_r.wRdy <= 1'b1;
         s_r.arRdy <= 1'b1;
         s_r.qmode <= QM_FOUR;
         s_r.rate <= {4{RST_RATE}};
         s_r.ratio <= {3{RST_RATIO}};
      end else begin
         s_r <= s_nxt;
      end
   end

   // every output is a flop bit; upper read data lanes are always zero
   assign awready = s_r.awRdy;
   assign wready = s_r.wRdy;
   assign bvalid = s_r.bValid;
   assign bresp = s_r.bResp;
   assign arready = s_r.arRdy;
   assign rvalid = s_r.rValid;
   assign rdata = {24'h000000, s_r.rData};
   assign rresp = s_r.rResp;
   assign port3Fiber = s_r.fiber;
   assign switchRxRefClockOut = s_r.refOut;
   assign queueByteSend = s_r.send;
endmodule

// ### verification/egress_partner.sv
// far side of the egress queues: offers bytes and counts the grants
`timescale 1ns/10ps
module egress_partner (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] offer,
   input wire logic slow,
   input wire logic clear,
   input wire logic [3:0] queueByteSend,
   output logic [3:0] queueByteReady,
   output logic [15:0] grants [4]
);
   logic phase;

   // a slow source has a byte waiting only every other cycle
   assign queueByteReady = offer & {4{!slow || phase}};

   // grant counters, cleared by the bench before each window
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase <= 1'h0;
         grants <= '{default: 16'h0000};
      end else begin
         phase <= !phase;
         for (int i = 0; i < 4; i++) begin
            if (clear) begin
               grants[i] <= 16'h0000;
            end else if (queueByteSend[i]) begin
               grants[i] <= grants[i] + 16'h0001;
            end
         end
      end
   end
endmodule

// ### verification/port_media_and_clock_phase_ctrl_properties.sv
// port-level assertions for the port media and clock phase register bank
`timescale 1ns/10ps
module port_media_and_clock_phase_ctrl_properties (
   input wire logic clk,
   input wire logic resetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic port3Fiber,
   input wire logic switchSideReducedMiiMode,
   input wire logic switchRxRefClockOut,
   input wire logic [3:0] queueByteReady,
   input wire logic [3:0] queueByteSend
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_b_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
      else $error("write answer missing");
   chk_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   chk_r_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer missing");
   chk_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   chk_rdata_narrow: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   // media only moves as a write completes
   chk_fiber_write: assert property ($changed(port3Fiber) |-> bvalid || $past(bvalid))
      else $error("media changed without write");
   // a phase flip holds the clock for one cycle just after its write
   chk_clk_toggles: assert property (
      switchSideReducedMiiMode [*3] ##0 !$past(bvalid) |-> $changed(switchRxRefClockOut))
      else $error("rx clock not toggling");
   chk_clk_quiet: assert property (!switchSideReducedMiiMode [*2] |-> !switchRxRefClockOut)
      else $error("rx clock runs outside rmii");
   chk_send_onehot: assert property ($onehot0(queueByteSend))
      else $error("several queues granted");
   chk_send_ready: assert property (
      |queueByteSend |-> (queueByteSend & ~$past(queueByteReady)) == 4'h0)
      else $error("grant without waiting byte");

   cov_write: cover property (bvalid && bready);
   cov_read: cover property (rvalid && rready);
   cov_top: cover property (queueByteSend[3]);
   cov_lower: cover property (queueByteSend[2]);
endmodule

bind port_media_and_clock_phase_ctrl port_media_and_clock_phase_ctrl_properties props (
   .clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .port3Fiber(port3Fiber), .switchSideReducedMiiMode(switchSideReducedMiiMode),
   .switchRxRefClockOut(switchRxRefClockOut), .queueByteReady(queueByteReady),
   .queueByteSend(queueByteSend));

// ### verification/port_media_and_clock_phase_ctrl_tb.sv
// self-checking bench for the port media and clock phase register bank
`timescale 1ns/10ps
module port_media_and_clock_phase_ctrl_tb;
   import port_media_pkg::*;
   localparam int SPAN = 4000;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [3:0] wstrb = 4'h1;
   logic rmiiMode = 1'h0, slow = 1'h0, clear = 1'h0, par = 1'h0, rel0;
   logic [3:0] offer = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, port3Fiber, clkOut;
   logic [1:0] bresp, rresp;
   logic [DATA_W-1:0] rdata, rdata2;
   logic [3:0] qReady, qSend;
   logic [15:0] grants [4];
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   logic [31:0] seed = 32'h0000EEE8;
   logic [6:0] codes [5] = '{7'h01, 7'h63, 7'h73, 7'h64, 7'h00};
   logic slows [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
   logic [6:0] ratios [2] = '{7'h40, 7'h20};
   int nFail = 0, totalChecks = 0, kbps, expN;

   always #5 clk = !clk;
   // parity reference to measure the rx clock phase against
   always @(posedge clk) par <= !par;

   port_media_and_clock_phase_ctrl dut (.clk(clk), .resetn(resetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .port3Fiber(port3Fiber), .switchSideReducedMiiMode(rmiiMode),
      .switchRxRefClockOut(clkOut), .queueByteReady(qReady), .queueByteSend(qSend));
   // second copy without the phase option, answering in lockstep with dut
   port_media_and_clock_phase_ctrl #(.HAS_CLK_INVERT(1'b0)) dutPlain (.clk(clk),
      .resetn(resetn), .awvalid(awvalid), .awready(), .awaddr(awaddr), .wvalid(wvalid),
      .wready(), .wdata(wdata), .wstrb(wstrb), .bvalid(), .bready(bready), .bresp(),
      .arvalid(arvalid), .arready(), .araddr(araddr), .rvalid(), .rready(rready),
      .rdata(rdata2), .rresp(), .port3Fiber(), .switchSideReducedMiiMode(rmiiMode),
      .switchRxRefClockOut(), .queueByteReady(qReady), .queueByteSend());
   egress_partner peer (.clk(clk), .resetn(resetn), .offer(offer), .slow(slow), .clear(clear),
      .queueByteSend(qSend), .queueByteReady(qReady), .grants(grants));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nFail++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // counts may be off by up to tol bytes at the window edges
   task automatic near(input logic [15:0] seen, input int exp, input int tol);
      chk(64'((seen >= exp - tol && seen <= exp + tol) ? 16'(exp) : seen), 64'(exp));
   endtask

   // address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      @(posedge clk);
      ad = 1'h0;
      wd = 1'h0;
      bq.push_back(er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            ad = 1'h1;
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            wd = 1'h1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge clk); while (!bvalid);
      bready <= 1'h0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      rq.push_back({er, ed});
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'h0;
   endtask

   // drain stored credit first, then count grants over a fixed window
   task automatic pace(input logic [3:0] o, input logic s);
      offer <= o;
      slow <= s;
      repeat (1000) @(posedge clk);
      clear <= 1'h1;
      @(posedge clk);
      clear <= 1'h0;
      repeat (SPAN) @(posedge clk);
      offer <= 4'h0;
   endtask

   // answers are matched against the oldest note in order of issue
   always @(posedge clk) begin
      if (bvalid && bready) chk(64'(bresp), 64'(bq.pop_front()));
      if (rvalid && rready) chk(64'({rresp, rdata}), 64'(rq.pop_front()));
      if (rvalid && rready && araddr == ADDR_TEST_C) chk(64'(rdata2), 64'h0);
   end

   task automatic completeRun();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      rd(ADDR_RSVD_CTRL_A, 32'h15, RESP_OKAY);
      rd(ADDR_TEST_B, 32'h0C, RESP_OKAY);
      rd(ADDR_MEDIA, 32'h32, RESP_OKAY);
      rd(ADDR_TEST_C, 32'h00, RESP_OKAY);
      chk(64'(port3Fiber), 64'h0);
      $display("test reset values done");
      // read-only places keep their value, unmapped ones answer with an error
      wr(ADDR_RSVD_CTRL_A, (xs() & 32'hFFFFFF00) | 32'h15, RESP_OKAY);
      wr(ADDR_TEST_B, (xs() & 32'hFFFFFF00) | 32'h0C, RESP_OKAY);
      wr(12'h100, xs(), RESP_SLVERR);
      rd(12'h100, 32'h0, RESP_SLVERR);
      rd(ADDR_RSVD_CTRL_A, 32'h15, RESP_OKAY);
      rd(ADDR_TEST_B, 32'h0C, RESP_OKAY);
      $display("test protected places done");
      wr(ADDR_MEDIA, (xs() & 32'hFFFFFF00) | 32'hB2, RESP_OKAY);
      rd(ADDR_MEDIA, 32'hB2, RESP_OKAY);
      chk(64'(port3Fiber), 64'h1);
      wr(ADDR_MEDIA, (xs() & 32'hFFFFFF00) | 32'h32, RESP_OKAY);
      rd(ADDR_MEDIA, 32'h32, RESP_OKAY);
      chk(64'(port3Fiber), 64'h0);
      // a write with lane 0 off must leave the media bit alone
      wstrb <= 4'h0;
      wr(ADDR_MEDIA, (xs() & 32'hFFFFFF00) | 32'hB2, RESP_OKAY);
      wstrb <= 4'h1;
      rd(ADDR_MEDIA, 32'h32, RESP_OKAY);
      chk(64'(port3Fiber), 64'h0);
      $display("test media select done");
      rmiiMode <= 1'h1;
      repeat (4) @(negedge clk);
      rel0 = clkOut ^ par;
      @(negedge clk);
      chk(64'(clkOut ^ par), 64'(rel0));
      wr(ADDR_TEST_C, (xs() & 32'hFFFFFF00) | 32'h10, RESP_OKAY);
      rd(ADDR_TEST_C, 32'h10, RESP_OKAY);
      @(negedge clk);
      chk(64'(clkOut ^ par), 64'(!rel0));
      @(posedge clk);
      rmiiMode <= 1'h0;
      $display("test clock phase done");
      wr(ADDR_QUEUE_MODE, 32'h2, RESP_OKAY);
      foreach (codes[i]) begin
         wr(ADDR_RATE_Q3, 32'(codes[i]), RESP_OKAY);
         pace(4'h8, slows[i]);
         kbps = codes[i] <= 7'h63 ? codes[i] * 1000 : (codes[i] - 100) * 64;
         expN = (codes[i] == 0 || codes[i] == 100) ? SPAN >> slows[i] : SPAN * kbps / 800000;
         near(grants[3], expN, 1);
      end
      $display("test top queue rates done");
      wr(ADDR_RATE_Q3, 32'h0A, RESP_OKAY);
      foreach (ratios[i]) begin
         wr(ADDR_RATIO_Q2, 32'(ratios[i]), RESP_OKAY);
         pace(4'hC, 1'h0);
         near(grants[3], 50, 1);
         near(grants[2], 50 * ratios[i] / 64, 2);
      end
      $display("test weighted lower queue done");
      // two queues: queue 1 is the top, queue 3 above it gets nothing
      wr(ADDR_QUEUE_MODE, 32'h1, RESP_OKAY);
      rd(ADDR_QUEUE_MODE, 32'h1, RESP_OKAY);
      pace(4'hA, 1'h0);
      near(grants[3], 0, 0);
      near(grants[1], SPAN, 1);
      $display("test two queue mode done");
      completeRun();
   end

   initial begin
      repeat (60000) @(posedge clk);
      nFail++;
      completeRun();
   end
endmodule
